// ==== pcr_pkg.sv ====
// Constants, field layout and frame carrier of the pin and pulse configuration bank.
// Assumes a 40 MHz core clock and a 16-bit SPI frame sent least significant bit first.
package pcr_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int FRAME_BITS = 16;

    // ****************************************************************
    // Register offsets and reset values
    // ****************************************************************
    localparam logic [6:0] ADDR_PIN_CONFIG = 7'h17;
    localparam logic [6:0] ADDR_PULSE_ONE = 7'h18;
    localparam logic [6:0] ADDR_PULSE_TWO = 7'h19;
    localparam logic [6:0] ADDR_FREQ_SEL = 7'h1C;
    localparam logic [6:0] ADDR_RETAINED = 7'h1E;
    localparam logic [6:0] ADDR_EVENT_STATUS = 7'h40;
    localparam logic [7:0] RST_VALUE = 8'h00;

    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int FO_DUTY_LSB = 6;
    localparam int PIN_TWO_LSB = 3;
    localparam int PIN_ONE_LSB = 0;
    localparam int FREQ_ONE_BIT = 0;
    localparam int FREQ_TWO_BIT = 2;
    localparam logic [7:0] FREQ_MASK = 8'h05;
    localparam logic [2:0] MODE_WAKE = 3'h5;
    localparam logic [2:0] MODE_LOW_SIDE = 3'h6;
    localparam logic [2:0] MODE_HIGH_SIDE = 3'h7;
    localparam logic [1:0] FO_DUTY_10 = 2'h1;
    localparam logic [1:0] FO_DUTY_5 = 2'h2;
    localparam int FO_DIV_20 = 5;
    localparam int FO_DIV_10 = 10;
    localparam int FO_DIV_5 = 20;
    localparam logic [2:0] HS_PULSE_ONE = 3'h4;
    localparam logic [2:0] HS_PULSE_TWO = 3'h5;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int WAKE_FILT_US = 16;
    localparam int WAKE_FILT_CYC = (CLK_HZ / 1000 * WAKE_FILT_US + 999) / 1000;
    localparam int PWM_STEPS = 255;
    localparam int PWM_LOW_HZ = 200;
    localparam int PWM_HIGH_HZ = 400;
    localparam int PWM_LOW_CYC = CLK_HZ / (PWM_LOW_HZ * PWM_STEPS);
    localparam int PWM_HIGH_CYC = CLK_HZ / (PWM_HIGH_HZ * PWM_STEPS);

    typedef struct packed {
        logic [7:0] data;
        logic access;
        logic [6:0] addr;
    } pcr_cmd_t;

endpackage

// ==== pcr_top.sv ====
// Pin configuration and pulse generator register bank behind a 16-bit SPI slave.
// Assumes the host keeps the chip select high between frames long enough for
// the core clock to take the frame, and that sclk idles while the select is high.
`timescale 1ns/1ps

module pcr_top
    import pcr_pkg::*;
#(
    parameter int FO_PERIOD_CYC = 40000,
    parameter int WAKE_FILT = WAKE_FILT_CYC,
    parameter logic [7:0] STATUS_CLEARABLE = 8'hFF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic normal_operating_mode,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [7:0] status_events,
    input wire logic fail_active,
    input wire logic [11:0] high_side_switch_cfg,
    input wire logic [1:0] wake_pin_in,
    output logic [1:0] pin_low_side_on,
    output logic [1:0] pin_high_side_on,
    output logic [1:0] pin_fail_drive,
    output logic [1:0] pin_wake_en,
    output logic [1:0] wake_event,
    output logic pulse_one_out,
    output logic pulse_two_out,
    output logic [3:0] high_side_switch_pwm_on
);

    localparam int FOW = $clog2(FO_PERIOD_CYC + 1);
    localparam int WKW = $clog2(WAKE_FILT + 1);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // Link side shift logic
    // ****************************************************************
    logic [3:0] rx_cnt_ff;
    logic [14:0] rx_sh_ff;
    logic [15:0] rx_word_ff;
    logic rx_tgl_ff;
    logic [3:0] tx_idx_ff;
    logic [15:0] rsp_ff;

    always_ff @(posedge spi_sclk or posedge spi_csn) begin
        if (spi_csn) begin
            rx_cnt_ff <= 4'h0;
            rx_sh_ff <= 15'h0000;
        end else begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            rx_sh_ff <= {spi_mosi, rx_sh_ff[14:1]};
        end
    end

    // The word stays put until the next full frame, so the core reads it safely.
    always_ff @(posedge spi_sclk or negedge resetn) begin
        if (!resetn) begin
            rx_word_ff <= 16'h0000;
            rx_tgl_ff <= 1'b0;
        end else if (!spi_csn && rx_cnt_ff == 4'(FRAME_BITS - 1)) begin
            rx_word_ff <= {spi_mosi, rx_sh_ff};
            rx_tgl_ff <= ~rx_tgl_ff;
        end
    end

    always_ff @(negedge spi_sclk or posedge spi_csn) begin
        if (spi_csn) begin
            tx_idx_ff <= 4'h0;
        end else begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
        end
    end

    assign spi_miso = rsp_ff[tx_idx_ff];
    assign spi_miso_oe = ~spi_csn;

    // ****************************************************************
    // Frame hand-over into the core clock
    // ****************************************************************
    logic tgl_meta_ff;
    logic tgl_sync_ff;
    logic tgl_seen_ff;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end else begin
            tgl_meta_ff <= rx_tgl_ff;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
        end
    end

    pcr_cmd_t cmd;
    wire cmd_fire = tgl_sync_ff ^ tgl_seen_ff;
    // Data byte from frame bits 8 to 15.
    assign cmd = pcr_cmd_t'(rx_word_ff);
    wire cmd_wr = cmd_fire & cmd.access;

    // ****************************************************************
    // Register decode and storage
    // ****************************************************************
    wire hit_pin = cmd.addr == ADDR_PIN_CONFIG;
    wire hit_one = cmd.addr == ADDR_PULSE_ONE;
    wire hit_two = cmd.addr == ADDR_PULSE_TWO;
    wire hit_freq = cmd.addr == ADDR_FREQ_SEL;
    // Retained byte only in normal mode.
    wire hit_ret = (cmd.addr == ADDR_RETAINED) & normal_operating_mode;
    wire hit_stat = cmd.addr == ADDR_EVENT_STATUS;

    logic [7:0] pin_config_ff;
    logic [7:0] pulse_one_duty_ff;
    logic [7:0] pulse_two_duty_ff;
    logic [7:0] pulse_frequency_select_ff;
    logic [7:0] retained_system_byte_ff;
    logic [7:0] status_ff;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pin_config_ff <= RST_VALUE;
            pulse_one_duty_ff <= RST_VALUE;
            pulse_two_duty_ff <= RST_VALUE;
            pulse_frequency_select_ff <= RST_VALUE;
        end else if (soft_reset) begin
            pin_config_ff <= RST_VALUE;
            pulse_one_duty_ff <= RST_VALUE;
            pulse_two_duty_ff <= RST_VALUE;
            pulse_frequency_select_ff <= RST_VALUE;
        end else if (cmd_wr) begin
            if (hit_pin) begin
                pin_config_ff <= cmd.data;
            end
            if (hit_one) begin
                pulse_one_duty_ff <= cmd.data;
            end
            if (hit_two) begin
                pulse_two_duty_ff <= cmd.data;
            end
            if (hit_freq) begin
                pulse_frequency_select_ff <= cmd.data & FREQ_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            retained_system_byte_ff <= RST_VALUE;
        end else if (cmd_wr && hit_ret) begin
            retained_system_byte_ff <= cmd.data;
        end
    end

    wire [7:0] stat_clr = (cmd_wr && hit_stat) ? STATUS_CLEARABLE : 8'h00;
    // Clearable bits leave only by host clear or soft_reset; other bits follow the events.
    wire [7:0] nxt_status = (status_ff & ~stat_clr & STATUS_CLEARABLE)
                          | (status_events & ~STATUS_CLEARABLE) | status_events;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            status_ff <= RST_VALUE;
        end else if (soft_reset) begin
            status_ff <= RST_VALUE;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Whole byte returned without side effect.
    wire [7:0] rd_data = hit_pin ? pin_config_ff
                       : hit_one ? pulse_one_duty_ff
                       : hit_two ? pulse_two_duty_ff
                       : hit_freq ? pulse_frequency_select_ff
                       : hit_ret ? retained_system_byte_ff
                       : hit_stat ? status_ff
                       : 8'h00;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rsp_ff <= 16'h0000;
        end else if (cmd_fire) begin
            rsp_ff <= {rd_data, 1'b0, cmd.addr};
        end
    end

    // ****************************************************************
    // Pulse generators
    // ****************************************************************
    wire [7:0] duty_w [2];
    wire freq_w [2];
    logic pulse_w [2];
    assign duty_w[0] = pulse_one_duty_ff;
    assign duty_w[1] = pulse_two_duty_ff;
    assign freq_w[0] = pulse_frequency_select_ff[FREQ_ONE_BIT];
    assign freq_w[1] = pulse_frequency_select_ff[FREQ_TWO_BIT];

    for (genvar g = 0; g < 2; g++) begin : g_pulse
        logic [9:0] pre_ff;
        logic [7:0] step_ff;
        logic out_ff;
        wire [9:0] step_len = freq_w[g] ? 10'(PWM_HIGH_CYC) : 10'(PWM_LOW_CYC);
        wire step_end = pre_ff >= step_len - 10'h1;

        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                pre_ff <= 10'h000;
                step_ff <= 8'h00;
            end else if (step_end) begin
                pre_ff <= 10'h000;
                step_ff <= (step_ff == 8'(PWM_STEPS - 1)) ? 8'h00 : step_ff + 8'h01;
            end else begin
                pre_ff <= pre_ff + 10'h001;
            end
        end

        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                out_ff <= 1'b0;
            end else begin
                out_ff <= step_ff < duty_w[g];
            end
        end
        assign pulse_w[g] = out_ff;
    end

    assign pulse_one_out = pulse_w[0];
    assign pulse_two_out = pulse_w[1];

    for (genvar h = 0; h < 4; h++) begin : g_hs
        logic on_ff;
        wire [2:0] cfg = high_side_switch_cfg[3*h +: 3];
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                on_ff <= 1'b0;
            end else begin
                on_ff <= (cfg == HS_PULSE_ONE) ? pulse_w[0]
                       : (cfg == HS_PULSE_TWO) ? pulse_w[1] : 1'b0;
            end
        end
        assign high_side_switch_pwm_on[h] = on_ff;
    end

    // ****************************************************************
    // Fail output duty
    // ****************************************************************
    logic [FOW-1:0] fo_cnt_ff;
    wire [1:0] fail_output_duty = pin_config_ff[FO_DUTY_LSB +: 2];
    // Duty 20, 10 or 5 percent.
    wire [FOW-1:0] fo_on = (fail_output_duty == FO_DUTY_10) ? FOW'(FO_PERIOD_CYC / FO_DIV_10)
                         : (fail_output_duty == FO_DUTY_5) ? FOW'(FO_PERIOD_CYC / FO_DIV_5)
                         : FOW'(FO_PERIOD_CYC / FO_DIV_20);

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fo_cnt_ff <= '0;
        end else if (fo_cnt_ff == FOW'(FO_PERIOD_CYC - 1)) begin
            fo_cnt_ff <= '0;
        end else begin
            fo_cnt_ff <= fo_cnt_ff + FOW'(1);
        end
    end

    wire fail_output_b = fail_active;
    wire fail_output_c = fail_active & (fo_cnt_ff < fo_on);
    wire fail_w [2];
    assign fail_w[0] = fail_output_b;
    assign fail_w[1] = fail_output_c;

    // ****************************************************************
    // General pins and wake filters
    // ****************************************************************
    wire [2:0] mode_w [2];
    assign mode_w[0] = pin_config_ff[PIN_ONE_LSB +: 3];
    assign mode_w[1] = pin_config_ff[PIN_TWO_LSB +: 3];

    for (genvar p = 0; p < 2; p++) begin : g_pin
        logic wk_meta_ff;
        logic wk_sync_ff;
        logic [WKW-1:0] filt_ff;
        logic evt_ff;
        logic low_ff;
        logic high_ff;
        logic fail_ff;
        logic wake_en_ff;
        wire [2:0] m = mode_w[p];
        wire held = wake_en_ff & wk_sync_ff;

        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                wk_meta_ff <= 1'b0;
                wk_sync_ff <= 1'b0;
            end else begin
                wk_meta_ff <= wake_pin_in[p];
                wk_sync_ff <= wk_meta_ff;
            end
        end

        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                low_ff <= 1'b0;
                high_ff <= 1'b0;
                fail_ff <= 1'b0;
                wake_en_ff <= 1'b0;
            end else begin
                low_ff <= m == MODE_LOW_SIDE;
                high_ff <= m == MODE_HIGH_SIDE;
                fail_ff <= ~m[2] & fail_w[p];
                wake_en_ff <= m == MODE_WAKE;
            end
        end

        // Level must hold the whole filter time.
        always_ff @(posedge clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                filt_ff <= '0;
                evt_ff <= 1'b0;
            end else begin
                filt_ff <= !held ? '0
                         : (filt_ff == WKW'(WAKE_FILT)) ? filt_ff : filt_ff + WKW'(1);
                evt_ff <= held & (filt_ff == WKW'(WAKE_FILT - 1));
            end
        end

        assign pin_low_side_on[p] = low_ff;
        assign pin_high_side_on[p] = high_ff;
        assign pin_fail_drive[p] = fail_ff;
        assign pin_wake_en[p] = wake_en_ff;
        assign wake_event[p] = evt_ff;
    end

endmodule // pcr_top

// ==== pcr_checker.sv ====
// Concurrent checks for the pin and pulse configuration bank.
// Sees only the ports of pcr_top and is bound to it at the foot of this file.
`timescale 1ns/1ps

module pcr_checker
    import pcr_pkg::*;
#(
    parameter int WAKE_FILT = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic [11:0] high_side_switch_cfg,
    input wire logic [1:0] wake_pin_in,
    input wire logic [1:0] pin_low_side_on,
    input wire logic [1:0] pin_high_side_on,
    input wire logic [1:0] pin_wake_en,
    input wire logic [1:0] wake_event,
    input wire logic pulse_one_out,
    input wire logic pulse_two_out,
    input wire logic [3:0] high_side_switch_pwm_on
);
    logic [9:0] run_ff;
    logic [4:0] edge_ff;

    // Counts how long the raw wake pin of pin one has been high.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) run_ff <= 10'h000;
        else if (!wake_pin_in[0]) run_ff <= 10'h000;
        else if (run_ff != 10'h3FF) run_ff <= run_ff + 10'h001;
    end

    // Counts rising link clock edges within a frame.
    always_ff @(posedge spi_sclk or posedge spi_csn) begin
        if (spi_csn) edge_ff <= 5'h00;
        else edge_ff <= edge_ff + 5'h01;
    end

    a_oe_tracks_select: assert property (@(posedge clk) disable iff (!resetn)
        spi_miso_oe == !spi_csn) else $error("miso enable does not follow select");
    a_modes_exclusive: assert property (@(posedge clk) disable iff (!resetn)
        $onehot0({pin_low_side_on[0], pin_high_side_on[0], pin_wake_en[0]}) &&
        $onehot0({pin_low_side_on[1], pin_high_side_on[1], pin_wake_en[1]}))
        else $error("pin drives more than one mode");
    // The event shows three edges after the last pin sample that the filter used.
    a_wake_filtered: assert property (@(posedge clk) disable iff (!resetn)
        wake_event[0] |-> int'($past(run_ff, 2)) >= WAKE_FILT)
        else $error("wake without filter time");
    a_wake_single: assert property (@(posedge clk) disable iff (!resetn)
        wake_event[0] |=> !wake_event[0]) else $error("wake event longer than one cycle");
    a_switch_pulse_one: assert property (@(posedge clk) disable iff (!resetn)
        $past(high_side_switch_cfg[2:0]) == HS_PULSE_ONE |->
        high_side_switch_pwm_on[0] == $past(pulse_one_out)) else $error("switch 0 not on pulse one");
    a_switch_pulse_two: assert property (@(posedge clk) disable iff (!resetn)
        $past(high_side_switch_cfg[5:3]) == HS_PULSE_TWO |->
        high_side_switch_pwm_on[1] == $past(pulse_two_out)) else $error("switch 1 not on pulse two");
    a_switch_idle_low: assert property (@(posedge clk) disable iff (!resetn)
        $past(high_side_switch_cfg[8:6]) != HS_PULSE_ONE &&
        $past(high_side_switch_cfg[8:6]) != HS_PULSE_TWO |-> !high_side_switch_pwm_on[2])
        else $error("switch 2 pulsed without pulse code");
    a_resp_bit7_zero: assert property (@(posedge spi_sclk) disable iff (spi_csn || !resetn)
        edge_ff == 5'h07 |-> !spi_miso) else $error("response access bit not zero");

    c_wake: cover property (@(posedge clk) wake_event[0]);
    c_switch_two: cover property (@(posedge clk) high_side_switch_pwm_on[1]);
    c_pulse_rise: cover property (@(posedge clk) $rose(pulse_one_out));
endmodule // pcr_checker

bind pcr_top pcr_checker #(.WAKE_FILT(WAKE_FILT)) u_checker (.clk, .resetn, .spi_sclk,
    .spi_csn, .spi_miso, .spi_miso_oe, .high_side_switch_cfg, .wake_pin_in, .pin_low_side_on,
    .pin_high_side_on, .pin_wake_en, .wake_event, .pulse_one_out, .pulse_two_out,
    .high_side_switch_pwm_on);

// ==== pcr_host_model.sv ====
// Host model: SPI master sending frames of nbits bits, at most 16, to the configuration bank.
// Assumes a 32 ns link clock that runs only while the select is low.
`timescale 1ns/1ps

module pcr_host_model (
    output logic spi_sclk,
    output logic spi_csn,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_csn = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rsp);
        rsp = 16'h0000;
        spi_csn = 1'b0;
        spi_mosi = word[0];
        #16;
        for (int k = 0; k < nbits; k++) begin
            rsp[k] = spi_miso;
            spi_sclk = 1'b1;
            #16;
            spi_sclk = 1'b0;
            if (k + 1 < nbits) spi_mosi = word[k + 1];
            #16;
        end
        spi_csn = 1'b1;
        // A released data line shows the inverse of its last value.
        spi_mosi = !spi_mosi;
        #250;
    endtask
endmodule // pcr_host_model

// ==== pin_pwm_config_registers_test.sv ====
// Self-checking bench for the pin and pulse configuration bank.
// Assumes pcr_top, the checker and the host model are compiled first.
`timescale 1ns/1ps

module pin_pwm_config_registers_test;
    import pcr_pkg::*;
    localparam int FO_PER = 100;
    localparam int WFILT = 8;
    logic clk, resetn, soft_reset, normal_operating_mode, fail_active;
    logic spi_sclk, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
    logic [7:0] status_events;
    logic [11:0] high_side_switch_cfg;
    logic [1:0] wake_pin_in, pin_low_side_on, pin_high_side_on, pin_fail_drive;
    logic [1:0] pin_wake_en, wake_event;
    logic pulse_one_out, pulse_two_out;
    logic [3:0] high_side_switch_pwm_on;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int wake_seen = 0;
    int mreg[int];
    int cfg_addr[6] = '{'h17, 'h18, 'h19, 'h1C, 'h1E, 'h40};
    logic [15:0] exp_rsp = 16'h0000;
    logic exp_ok = 1'b0;

    pcr_top #(.FO_PERIOD_CYC(FO_PER), .WAKE_FILT(WFILT), .STATUS_CLEARABLE(8'hFF)) dut (
        .clk, .resetn, .soft_reset, .normal_operating_mode, .spi_sclk, .spi_csn, .spi_mosi,
        .spi_miso, .spi_miso_oe, .status_events, .fail_active, .high_side_switch_cfg,
        .wake_pin_in, .pin_low_side_on, .pin_high_side_on, .pin_fail_drive, .pin_wake_en,
        .wake_event, .pulse_one_out, .pulse_two_out, .high_side_switch_pwm_on);
    pcr_host_model host (.spi_sclk, .spi_csn, .spi_mosi, .spi_miso);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        wake_seen <= wake_seen + int'(wake_event[0]) + int'(wake_event[1]);
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    // ********
    // Helpers
    // ********
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic int rd(input logic [6:0] a);
        if (a == ADDR_RETAINED && !normal_operating_mode) return 0;
        return mreg.exists(int'(a)) ? mreg[int'(a)] : 0;
    endfunction

    // Expected switch levels: code 100 follows pulse one, 101 pulse two, else low.
    function automatic logic [3:0] hs_exp(input logic [11:0] c, input logic a, input logic b);
        for (int h = 0; h < 4; h++) begin
            hs_exp[h] = (c[3*h +: 3] == HS_PULSE_ONE) ? a
                      : (c[3*h +: 3] == HS_PULSE_TWO) ? b : 1'b0;
        end
    endfunction

    // One frame; the answer to the previous frame, read or write, is compared with the model.
    task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d);
        pcr_cmd_t c;
        logic [15:0] r;
        int v;
        c = '{data: d, access: w, addr: a};
        host.xfer(c, 16, r);
        @(negedge clk);
        if (exp_ok) chk("response", r, exp_rsp);
        v = rd(a);
        exp_rsp = {v[7:0], 1'b0, a};
        exp_ok = 1'b1;
        if (w && mreg.exists(int'(a)) && (a != ADDR_RETAINED || normal_operating_mode)) begin
            mreg[a] = (a == ADDR_FREQ_SEL) ? int'(d & FREQ_MASK) :
                (a == ADDR_EVENT_STATUS) ? 0 : int'(d);
        end
    endtask

    // ********
    // Tests
    // ********
    initial begin
        logic [7:0] d;
        logic [2:0] m;
        logic [3:0] hx;
        logic [15:0] r;
        int f;
        int cnt;
        resetn = 1'b0;
        soft_reset = 1'b0;
        normal_operating_mode = 1'b1;
        fail_active = 1'b1;
        status_events = 8'h00;
        high_side_switch_cfg = 12'h02C;
        wake_pin_in = 2'b00;
        void'($urandom(90412));
        foreach (cfg_addr[i]) mreg[cfg_addr[i]] = 0;
        tick(4);
        resetn = 1'b1;
        tick(4);
        foreach (cfg_addr[i]) acc(cfg_addr[i][6:0], 1'b0, 8'h00);
        acc(7'h7F, 1'b0, 8'h00);
        $display("test reset_values done");
        repeat (4) begin
            foreach (cfg_addr[i]) begin
                d = 8'($urandom);
                acc(cfg_addr[i][6:0], 1'b1, d);
                acc(cfg_addr[i][6:0], 1'b0, 8'h00);
            end
        end
        acc(7'h20, 1'b0, 8'h00);
        $display("test write_read done");
        for (int k = 0; k < 8; k++) begin
            m = 3'(k);
            acc(ADDR_PIN_CONFIG, 1'b1, {2'b00, m, m});
            tick(4);
            chk("low side", 16'(pin_low_side_on), 16'({2{m == MODE_LOW_SIDE}}));
            chk("high side", 16'(pin_high_side_on), 16'({2{m == MODE_HIGH_SIDE}}));
            chk("wake enable", 16'(pin_wake_en), 16'({2{m == MODE_WAKE}}));
            chk("fail pin one", 16'(pin_fail_drive[0]), 16'(m < 3'h4));
        end
        $display("test pin_modes done");
        for (int k = 0; k < 4; k++) begin
            acc(ADDR_PIN_CONFIG, 1'b1, {2'(k), 6'h00});
            tick(2 * FO_PER);
            cnt = 0;
            repeat (FO_PER) begin
                @(negedge clk);
                cnt += int'(pin_fail_drive[1]);
            end
            f = (k == 1) ? FO_DIV_10 : (k == 2) ? FO_DIV_5 : FO_DIV_20;
            chk("fail duty", 16'(cnt), 16'(FO_PER / f));
        end
        $display("test fail_duty done");
        acc(ADDR_PIN_CONFIG, 1'b1, {2'b00, 3'h4, MODE_WAKE});
        tick(4);
        f = wake_seen;
        wake_pin_in = 2'b01;
        tick(WFILT - 3);
        wake_pin_in = 2'b00;
        tick(20);
        wake_pin_in = 2'b11;
        tick(WFILT + 12);
        wake_pin_in = 2'b00;
        tick(20);
        chk("wake events", 16'(wake_seen - f), 16'h0001);
        $display("test wake_filter done");
        for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 8'hFF : 8'h00;
            acc(ADDR_PULSE_ONE, 1'b1, d);
            acc(ADDR_PULSE_TWO, 1'b1, ~d);
            acc(ADDR_FREQ_SEL, 1'b1, 8'($urandom));
            repeat (3) begin
                high_side_switch_cfg = 12'($urandom);
                tick(400);
                hx = hs_exp(high_side_switch_cfg, d[0], ~d[0]);
                chk("pulses", 16'({pulse_two_out, pulse_one_out}), 16'({~d[0], d[0]}));
                chk("switch pwm", 16'(high_side_switch_pwm_on), 16'(hx));
            end
        end
        $display("test pulse_levels done");
        acc(ADDR_RETAINED, 1'b1, 8'hA5);
        normal_operating_mode = 1'b0;
        acc(ADDR_RETAINED, 1'b1, 8'h3C);
        acc(ADDR_RETAINED, 1'b0, 8'h00);
        normal_operating_mode = 1'b1;
        acc(ADDR_RETAINED, 1'b0, 8'h00);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        foreach (cfg_addr[i]) if (cfg_addr[i] != 'h1E) mreg[cfg_addr[i]] = 0;
        foreach (cfg_addr[i]) acc(cfg_addr[i][6:0], 1'b0, 8'h00);
        resetn = 1'b0;
        tick(4);
        resetn = 1'b1;
        tick(4);
        foreach (cfg_addr[i]) mreg[cfg_addr[i]] = 0;
        exp_ok = 1'b0;
        acc(ADDR_RETAINED, 1'b0, 8'h00);
        acc(7'h20, 1'b0, 8'h00);
        $display("test retained done");
        d = 8'($urandom) | 8'h01;
        status_events = d;
        tick(1);
        status_events = 8'h00;
        mreg[ADDR_EVENT_STATUS] = d;
        acc(ADDR_EVENT_STATUS, 1'b0, 8'h00);
        tick(50);
        acc(ADDR_EVENT_STATUS, 1'b0, 8'h00);
        acc(ADDR_EVENT_STATUS, 1'b1, 8'h00);
        acc(ADDR_EVENT_STATUS, 1'b0, 8'h00);
        acc(7'h20, 1'b0, 8'h00);
        $display("test status done");
        host.xfer({8'h77, 1'b1, ADDR_PULSE_ONE}, 8, r);
        @(negedge clk);
        acc(ADDR_PULSE_ONE, 1'b0, 8'h00);
        acc(7'h20, 1'b0, 8'h00);
        $display("test short_frame done");
        end_of_test();
    end
endmodule // pin_pwm_config_registers_test
